// >>> inc/lin_params.svh
// Constants of the second LIN transceiver control
`ifndef LIN_PARAMS_SVH
`define LIN_PARAMS_SVH
`define LIN_CLK_PERIOD_PS 5000
// Internal clock cycles per microsecond, kept apart so products stay inside 32 bits
`define LIN_CYCLES_PER_US (1000 * 1000 / `LIN_CLK_PERIOD_PS)
`define LIN_QUAL_TIME_NS 10000
`define LIN_QUAL_CYCLES (`LIN_QUAL_TIME_NS * 1000 / `LIN_CLK_PERIOD_PS)
`define LIN_DOM_TIMEOUT_US 20000
`define LIN_RELEASE_US 10
`define LIN_CNT_W 24
`define LIN_CNT_MAX 24'hFFFFFF
`endif

// >>> inc/lin_pkg.sv
// Types of the second LIN transceiver control
package lin_pkg;
  typedef enum logic [1:0] {
    MODE_FAILSAFE,
    MODE_NORMAL,
    MODE_SILENT,
    MODE_SLEEP
  } lin_mode_t;
endpackage

// >>> inc/txgate_if.sv
// Carrier between mode control and transmit gate
`timescale 1ns/1ps
interface txgate_if;
  logic tx_level;
  logic normal;
  logic entry;
  logic drive_ok;
  logic timed_out;
  modport ctrl (output tx_level, output normal, output entry, input drive_ok, input timed_out);
  modport gate (input tx_level, input normal, input entry, output drive_ok, output timed_out);
endinterface

// >>> logic/tx_gate.sv
// Transmit gating: entry lock-out and dominant time-out
`timescale 1ns/1ps
`include "lin_params.svh"
module tx_gate
  import lin_pkg::*;
#(
  parameter int unsigned DOM_CYCLES = 32'd4000000,
  parameter int unsigned REL_CYCLES = 32'd2000
) (
  input wire logic clk_i,
  input wire logic rst_n,
  txgate_if.gate tg
);
  logic [`LIN_CNT_W-1:0] high_cnt_ff;
  logic [`LIN_CNT_W-1:0] low_cnt_ff;
  logic blocked_ff;
  logic timed_out_ff;

  // ****************************************
  // Level duration counters
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_ff <= '0;
      low_cnt_ff <= '0;
    end else begin
      if (!tg.tx_level) begin
        high_cnt_ff <= '0;
      end else if (high_cnt_ff != `LIN_CNT_MAX) begin
        high_cnt_ff <= high_cnt_ff + 1'b1;
      end
      if (tg.tx_level) begin
        low_cnt_ff <= '0;
      end else if (low_cnt_ff != `LIN_CNT_MAX) begin
        low_cnt_ff <= low_cnt_ff + 1'b1;
      end
    end
  end

  // ****************************************
  // Lock-out after entry with input low
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      blocked_ff <= 1'b0;
    end else if (tg.entry && !tg.tx_level) begin
      blocked_ff <= 1'b1; // [R2]
    end else if (tg.tx_level && 32'(high_cnt_ff) >= `LIN_QUAL_CYCLES) begin
      blocked_ff <= 1'b0; // [R2] [R15]
    end
  end

  // ****************************************
  // Dominant time-out and release
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timed_out_ff <= 1'b0;
    end else if (!tg.tx_level && 32'(low_cnt_ff) >= DOM_CYCLES) begin
      timed_out_ff <= 1'b1; // [R3] [R15]
    end else if (tg.tx_level && 32'(high_cnt_ff) + 32'd1 >= REL_CYCLES) begin
      timed_out_ff <= 1'b0; // [R4]
    end
  end

  assign tg.drive_ok = tg.normal && !blocked_ff && !timed_out_ff;
  assign tg.timed_out = timed_out_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_entry_lockout: assert property ( // [R2]
    tg.entry && !tg.tx_level |=> !tg.drive_ok)
    else $error("driver enabled despite low input at entry");
  a_lockout_hold: assert property ( // [R2]
    blocked_ff && !tg.tx_level |=> blocked_ff)
    else $error("lock-out released while input low");
  a_timeout_set: assert property ( // [R3]
    !tg.tx_level && 32'(low_cnt_ff) >= DOM_CYCLES |=> timed_out_ff)
    else $error("dominant time-out missed");
  a_release_wait: assert property ( // [R4]
    timed_out_ff && !tg.tx_level ##1 tg.tx_level |-> timed_out_ff)
    else $error("time-out cleared too early");
endmodule // tx_gate

// >>> logic/lin_transceiver_control.sv
// Second LIN transceiver digital control
// Contract
// [R1] Low input drives bus dominant, high recessive
// [R2] Low at Normal entry blocks until high
// [R3] Long low input forces bus recessive
// [R4] Re-enable after high for release period
// [R5] Normal mode receive output mirrors bus
// [R6] Silent mode holds receive output high
// [R7] Fail-safe reports source on transmit/receive pins
// [R8] Overtemperature switches bus output off
// [R9] Enable high selects Normal, regulator on
// [R10] Enable low, input high: Silent
// [R11] Enable low, input low: Sleep
// [R12] Floating enable reads low
// [R13] Mode change and wake despite shorted bus
// [R14] Supply power-up starts in Fail-Safe
// [R15] Timers count internal clock, parameterised
`timescale 1ns/1ps
`include "lin_params.svh"
module lin_transceiver_control
  import lin_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT_CYCLES = `LIN_DOM_TIMEOUT_US * `LIN_CYCLES_PER_US,
  parameter int unsigned RELEASE_CYCLES = `LIN_RELEASE_US * `LIN_CYCLES_PER_US
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic second_battery_supply_good_i,
  input wire logic second_lin_enable_in_i,
  input wire logic second_lin_tx_in_i,
  output logic second_lin_tx_in_o,
  output logic second_lin_tx_in_oe_o,
  output logic second_lin_rx_out_o,
  input wire logic second_bus_line_i,
  output logic second_bus_line_drive_o,
  input wire logic temp_above_limit_i,
  input wire logic temp_below_hyst_i,
  input wire logic [1:0] failsafe_source_i,
  output logic regulator_on_o,
  output logic bus_wake_o,
  output logic timeout_active_o
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  lin_mode_t mode_ff;
  lin_mode_t nxt_mode;
  logic supply_ff;
  logic overtemp_ff;
  logic dom_seen_ff;
  logic wake_ff;
  logic drive_ff;
  logic rx_ff;
  txgate_if tg ();

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ****************************************
  // Mode control
  // ****************************************
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_FAILSAFE: begin
        if (second_lin_enable_in_i) begin
          nxt_mode = MODE_NORMAL; // [R9]
        end
      end
      MODE_NORMAL: begin
        if (!second_lin_enable_in_i && second_lin_tx_in_i) begin
          nxt_mode = MODE_SILENT; // [R10] [R12] [R13]
        end else if (!second_lin_enable_in_i) begin
          nxt_mode = MODE_SLEEP; // [R11] [R12] [R13]
        end
      end
      MODE_SILENT: begin
        if (second_lin_enable_in_i) begin
          nxt_mode = MODE_NORMAL; // [R9]
        end else if (!second_lin_tx_in_i) begin
          nxt_mode = MODE_SLEEP; // [R11]
        end
      end
      MODE_SLEEP: begin
        if (second_lin_enable_in_i) begin
          nxt_mode = MODE_NORMAL; // [R9]
        end else if (wake_ff) begin
          nxt_mode = MODE_FAILSAFE; // [R13]
        end
      end
    endcase
    if (!second_battery_supply_good_i || !supply_ff) begin
      nxt_mode = MODE_FAILSAFE; // [R14]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_FAILSAFE; // [R14]
      supply_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      supply_ff <= second_battery_supply_good_i;
    end
  end

  // ****************************************
  // Overtemperature with hysteresis
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overtemp_ff <= 1'b0;
    end else if (temp_above_limit_i) begin
      overtemp_ff <= 1'b1; // [R8]
    end else if (temp_below_hyst_i) begin
      overtemp_ff <= 1'b0; // [R8]
    end
  end

  // ****************************************
  // Remote wake in low-power modes
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dom_seen_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (mode_ff == MODE_SLEEP || mode_ff == MODE_SILENT) begin
      dom_seen_ff <= !second_bus_line_i;
      wake_ff <= dom_seen_ff && second_bus_line_i; // [R13]
    end else begin
      dom_seen_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
  end
  assign bus_wake_o = wake_ff;

  // ****************************************
  // Transmit gate
  // ****************************************
  assign tg.tx_level = second_lin_tx_in_i;
  assign tg.normal = (mode_ff == MODE_NORMAL);
  assign tg.entry = (nxt_mode == MODE_NORMAL) && (mode_ff != MODE_NORMAL);

  tx_gate #(
    .DOM_CYCLES(DOM_TIMEOUT_CYCLES),
    .REL_CYCLES(RELEASE_CYCLES)
  ) u_tx_gate (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .tg(tg.gate)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive_ff <= 1'b0;
    end else begin
      // Gated by the next mode so leaving Normal never leaks a dominant cycle
      drive_ff <= tg.drive_ok && (nxt_mode == MODE_NORMAL) && !second_lin_tx_in_i
        && !overtemp_ff; // [R1] [R3] [R8] [R10]
    end
  end
  assign second_bus_line_drive_o = drive_ff;
  assign timeout_active_o = tg.timed_out;

  // ****************************************
  // Receive output and fail-safe signalling
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_ff <= 1'b1;
    end else begin
      unique case (nxt_mode)
        MODE_NORMAL: rx_ff <= second_bus_line_i; // [R5] [R8]
        MODE_SILENT: rx_ff <= 1'b1; // [R6]
        MODE_SLEEP: rx_ff <= 1'b1;
        MODE_FAILSAFE: rx_ff <= failsafe_source_i[0]; // [R7]
      endcase
    end
  end
  assign second_lin_rx_out_o = rx_ff;
  assign second_lin_tx_in_oe_o = (mode_ff == MODE_FAILSAFE); // [R7]
  assign second_lin_tx_in_o = failsafe_source_i[1]; // [R7]
  assign regulator_on_o = (mode_ff != MODE_SLEEP); // [R9] [R11] [R14]

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_normal_low;
    mode_ff == MODE_NORMAL && !second_lin_enable_in_i;
  endsequence

  a_high_recessive: assert property ( // [R1]
    second_lin_tx_in_i |=> !second_bus_line_drive_o)
    else $error("bus driven while input high");
  a_rx_mirror: assert property ( // [R5]
    mode_ff == MODE_NORMAL && nxt_mode == MODE_NORMAL |=> rx_ff == $past(second_bus_line_i))
    else $error("receive output does not follow bus");
  a_silent_rx: assert property ( // [R6]
    mode_ff == MODE_SILENT |-> second_lin_rx_out_o)
    else $error("receive output low in Silent");
  a_failsafe_pins: assert property ( // [R7]
    mode_ff == MODE_FAILSAFE |-> second_lin_tx_in_oe_o && !second_bus_line_drive_o)
    else $error("fail-safe signalling wrong");
  a_overtemp_off: assert property ( // [R8]
    overtemp_ff |=> !second_bus_line_drive_o)
    else $error("bus driven in overtemperature");
  a_enable_normal: assert property ( // [R9]
    mode_ff == MODE_FAILSAFE && second_lin_enable_in_i && second_battery_supply_good_i
      && supply_ff |=> mode_ff == MODE_NORMAL ##0 regulator_on_o)
    else $error("enable high did not select Normal");
  a_to_silent: assert property ( // [R10]
    s_normal_low ##0 second_lin_tx_in_i && supply_ff && second_battery_supply_good_i
      |=> mode_ff == MODE_SILENT ##1 !second_bus_line_drive_o)
    else $error("Silent not entered");
  a_to_sleep: assert property ( // [R11]
    s_normal_low ##0 !second_lin_tx_in_i && supply_ff && second_battery_supply_good_i
      |=> mode_ff == MODE_SLEEP ##0 !regulator_on_o)
    else $error("Sleep not entered");
  a_power_up: assert property ( // [R14]
    !second_battery_supply_good_i |=> mode_ff == MODE_FAILSAFE && regulator_on_o)
    else $error("supply loss did not select Fail-Safe");
  a_drive_normal_only: assert property ( // [R10]
    mode_ff != MODE_NORMAL |-> !second_bus_line_drive_o)
    else $error("bus driven outside Normal");
endmodule // lin_transceiver_control

// >>> verification/lin_far_side.sv
// Host transmit pin and LIN bus with one remote node
`timescale 1ns/1ps
module lin_far_side (
  input wire logic host_tx_i,
  input wire logic dut_tx_i,
  input wire logic dut_tx_oe_i,
  input wire logic drive_i,
  input wire logic remote_dom_i,
  output logic tx_pin_o,
  output logic bus_o
);
  // ****************
  // Pin resolution
  // ****************
  // Device owns the transmit pin while it reports its fail-safe cause
  assign tx_pin_o = dut_tx_oe_i ? dut_tx_i : host_tx_i;
  // Wired-AND bus, recessive through the pull-up
  assign bus_o = !(drive_i || remote_dom_i);
endmodule // lin_far_side

// >>> verification/test_lin_transceiver_control.sv
// Self-checking bench of the second LIN transceiver control
`timescale 1ns/1ps
module test_lin_transceiver_control;
  logic clk = 1'b0, rstn = 1'b0, sup = 1'b1, en = 1'b0, htx = 1'b1, rem = 1'b0;
  logic hot = 1'b0, cool = 1'b0;
  logic [1:0] src = 2'h0, r;
  logic tx_o, oe, rx, drv, reg_on, wake, tmo, tx_pin, bus;
  int n_errors = 0, total_checks = 0, cycles = 0, seed = 58305, i;
  localparam int DOM_TB = 50;
  localparam int REL_TB = 10;
  int m_low = 0, m_high = 0;
  logic m_tmo = 1'b0;
  always #2.5 clk = ~clk;
  lin_transceiver_control #(.DOM_TIMEOUT_CYCLES(DOM_TB), .RELEASE_CYCLES(REL_TB)) u_dut (
    .clk_i(clk), .rstn_i(rstn), .second_battery_supply_good_i(sup),
    .second_lin_enable_in_i(en), .second_lin_tx_in_i(tx_pin),
    .second_lin_tx_in_o(tx_o), .second_lin_tx_in_oe_o(oe),
    .second_lin_rx_out_o(rx), .second_bus_line_i(bus),
    .second_bus_line_drive_o(drv), .temp_above_limit_i(hot),
    .temp_below_hyst_i(cool), .failsafe_source_i(src), .regulator_on_o(reg_on),
    .bus_wake_o(wake), .timeout_active_o(tmo));
  lin_far_side u_far (.host_tx_i(htx), .dut_tx_i(tx_o), .dut_tx_oe_i(oe),
    .drive_i(drv), .remote_dom_i(rem), .tx_pin_o(tx_pin), .bus_o(bus));
  // ****************
  // Tasks
  // ****************
  task summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ck(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %b want %b", $time, g, e);
    end
  endtask
  task at(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task set(input logic e, input logic t, input logic d);
    @(posedge clk);
    en <= e;
    htx <= t;
    rem <= d;
  endtask
  task wk;
    int k, c;
    c = 0;
    for (k = 0; k < 5; k++) begin
      @(negedge clk);
      if (wake === 1'b1) c++;
    end
    ck(c == 1, 1'b1);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      summarize;
    end
  end
  // Reference model of the dominant time-out and its release
  always @(posedge clk) begin
    if (!rstn) begin
      m_low = 0;
      m_high = 0;
      m_tmo = 1'b0;
    end else if (!tx_pin) begin
      m_low = m_low + 1;
      m_high = 0;
      if (m_low > DOM_TB) m_tmo = 1'b1;
    end else begin
      m_high = m_high + 1;
      m_low = 0;
      if (m_high >= REL_TB) m_tmo = 1'b0;
    end
  end
  always @(negedge clk) begin
    if (rstn) ck(tmo, m_tmo);
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      src <= 2'(i);
      at(2);
      ck(tx_pin, src[1]);
      ck(rx, src[0]);
      ck(oe & reg_on, 1'b1);
    end
    set(1, 1, 0);
    at(3);
    ck(oe, 1'b0);
    ck(reg_on, 1'b1);
    for (i = 0; i < 40; i++) begin
      r = 2'($random(seed));
      set(1, r[0], r[1]);
      at(2);
      ck(drv, !r[0]);
      ck(rx, r[0] & !r[1]);
    end
    set(1, 1, 0);
    set(1, 0, 0);
    at(45);
    ck(drv, 1'b1);
    at(10);
    ck(drv, 1'b0);
    ck(tmo, 1'b1);
    set(1, 1, 0);
    at(5);
    ck(tmo, 1'b1);
    at(8);
    ck(tmo, 1'b0);
    set(1, 0, 0);
    at(3);
    ck(drv, 1'b1);
    @(posedge clk) hot <= 1'b1;
    at(3);
    ck(drv, 1'b0);
    ck(rx, 1'b1);
    @(posedge clk) hot <= 1'b0;
    at(3);
    ck(drv, 1'b0);
    @(posedge clk) cool <= 1'b1;
    at(3);
    ck(drv, 1'b1);
    @(posedge clk) cool <= 1'b0;
    set(0, 1, 0);
    at(3);
    ck(oe | drv, 1'b0);
    set(0, 1, 1);
    at(2);
    ck(rx, 1'b1);
    set(0, 1, 0);
    wk;
    set(1, 1, 0);
    at(3);
    set(1, 0, 1);
    set(0, 0, 1);
    at(3);
    ck(reg_on, 1'b0);
    ck(rx, 1'b1);
    @(posedge clk) src <= 2'h0;
    set(0, 0, 0);
    wk;
    at(2);
    ck(oe & reg_on, 1'b1);
    set(1, 0, 0);
    at(3);
    ck(oe | drv, 1'b0);
    set(1, 1, 0);
    repeat (1990) @(posedge clk);
    set(1, 0, 0);
    at(3);
    ck(drv, 1'b0);
    set(1, 1, 0);
    repeat (2010) @(posedge clk);
    set(1, 0, 0);
    at(3);
    ck(drv, 1'b1);
    @(posedge clk) sup <= 1'b0;
    at(2);
    ck(oe & reg_on, 1'b1);
    ck(drv, 1'b0);
    summarize;
  end
endmodule // test_lin_transceiver_control
